/* rrsse_alu.sv */
/*
 combinational datapath: rotate right through carry and literal minus
 accumulator with borrow flags. assumes operands come from registers.
*/
`timescale 1ns/100ps

module rrsse_alu (
    // operands
    input  wire logic [7:0]            acc,
    input  wire logic [7:0]            k,
    input  wire logic [7:0]            fval,
    input  wire logic                  cin,
    // results
    output rrsse_pkg::rrsse_alu_out_t  rot,
    output rrsse_pkg::rrsse_alu_out_t  sub
);

    logic [8:0] diff;
    logic [4:0] low;

    always_comb begin
        diff = {1'b0, k} - {1'b0, acc};
        low  = {1'b0, k[3:0]} - {1'b0, acc[3:0]};
        rot.res              = {cin, fval[7:1]};
        rot.carry            = fval[0];
        rot.half_borrow_flag = 1'b0;
        rot.zero             = (rot.res == 8'h00);
        sub.res              = diff[7:0];
        sub.carry            = ~diff[8];
        sub.half_borrow_flag = ~low[4];
        sub.zero             = (diff[7:0] == 8'h00);
    end

endmodule : rrsse_alu

/* rrsse_core.sv */
/*
 execution of return-with-literal, return, rotate right, power-down and
 literal-minus-accumulator, behind an ahb-lite slave. assumes one clock
 hclk, single word transfers, and software issuing one instruction at a time.
*/
`timescale 1ns/100ps
// Contract
// - return-with-literal loads literal into accumulator, pc from stack head.
// - return-with-literal takes two instruction cycles, flags unchanged.
// - rotate right through carry: old carry to bit 7, bit 0 to carry.
// - rotate destination bit 0 selects accumulator, 1 the file register.
// - plain return pops stack into pc, flags unchanged.
// - plain return takes two instruction cycles.
// - power-down clears power-down flag and sets time-out flag.
// - power-down clears watchdog counter and its prescaler.
// - after power-down the core halts with oscillator stopped.
// - subtract computes literal minus accumulator, two's complement.
// - subtract result to accumulator, updates carry, half borrow, zero.
`include "rrsse_params.svh"

module rrsse_core (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // core state
    output logic             busy,
    output logic             osc_stop
);

    rrsse_pkg::rrsse_state_t   r;
    rrsse_pkg::rrsse_state_t   n;
    rrsse_pkg::rrsse_alu_out_t rot;
    rrsse_pkg::rrsse_alu_out_t sub;
    logic [`RRSSE_PC_W-1:0]    stack_head;
    logic [`RRSSE_PTR_W-1:0]   sp_dec;
    logic [`RRSSE_PRE_W:0]     pre_inc;
    logic                      take;
    logic                      idle;
    logic                      running;
    logic                      exec_now;
    logic                      launch;
    logic                      mem_we;
    logic [`RRSSE_FA_W-1:0]    mem_addr;
    logic [7:0]                mem_wdata;
    logic [7:0]                mem_rdata;

    function automatic logic op_ok(input logic [2:0] op);
        op_ok = (op >= `RRSSE_OP_RET_LIT) && (op <= `RRSSE_OP_LIT_SUB);
    endfunction : op_ok

    function automatic logic [3:0] last_clk(input logic [2:0] op);
        if ((op == `RRSSE_OP_RET_LIT) || (op == `RRSSE_OP_RET)) begin
            last_clk = `RRSSE_LAST_2ICYC;
        end else begin
            last_clk = `RRSSE_LAST_1ICYC;
        end
    endfunction : last_clk

    // stack head and handy decodes
    assign sp_dec     = r.sp - 1'b1;
    assign stack_head = r.stk[sp_dec];
    assign idle       = (r.xs == rrsse_pkg::xs_idle);
    assign running    = (r.xs == rrsse_pkg::xs_run);
    assign take       = hsel && hready && htrans[1];
    assign exec_now   = running && (r.cyc == `RRSSE_EXEC_CLK);
    assign launch     = r.dp_wr && (r.dp_a == `RRSSE_A_INSTR) && idle
                        && op_ok(hwdata[`RRSSE_OP_MSB:`RRSSE_OP_LSB]);

    // file register port
    assign mem_addr  = running ? r.fa : r.faddr;
    assign mem_wdata = running ? rot.res : hwdata[7:0];
    assign mem_we    = (exec_now && (r.op == `RRSSE_OP_ROT_R) && r.d)
                       || (r.dp_wr && (r.dp_a == `RRSSE_A_FDATA) && idle);

    rrsse_fmem #(
        .AW (`RRSSE_FA_W),
        .DW (8)
    ) u_fmem (
        .hclk  (hclk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

    rrsse_alu u_alu (
        .acc  (r.acc),
        .k    (r.k),
        .fval (mem_rdata),
        .cin  (r.st.carry),
        .rot  (rot),
        .sub  (sub)
    );

    always_comb begin
        n = r;
        pre_inc = {1'b0, r.pre} + 1'b1;
        // bus address phase
        n.dp_wr = take && hwrite;
        if (take) begin
            n.dp_a = (haddr[31:8] == 24'h000000) ? haddr[7:0] : `RRSSE_A_NONE;
        end
        if (take && !hwrite) begin
            n.rd_wait = `RRSSE_RD_WAITS;
        end else if (r.rd_wait != 2'h0) begin
            n.rd_wait = r.rd_wait - 2'h1;
        end
        // read data, captured in the last wait cycle
        if (r.rd_wait == `RRSSE_RD_CAPTURE) begin
            unique case (r.dp_a)
                `RRSSE_A_INSTR: n.rdata = {8'h00, r.d, r.fa, r.k, 5'h00, r.op};
                `RRSSE_A_ACC:   n.rdata = {24'h000000, r.acc};
                `RRSSE_A_FLAGS: n.rdata = {27'h0000000, r.st};
                `RRSSE_A_PC:    n.rdata = {19'h00000, r.pc};
                `RRSSE_A_STACK: n.rdata = {13'h0000, r.sp, 3'h0, stack_head};
                `RRSSE_A_CTRL:  n.rdata = {16'h0000, r.watchdog_counter, 6'h00,
                                           (r.xs == rrsse_pkg::xs_sleep), !idle};
                `RRSSE_A_FADDR: n.rdata = {25'h0000000, r.faddr};
                `RRSSE_A_FDATA: n.rdata = {24'h000000, mem_rdata};
                default:        n.rdata = 32'h00000000;
            endcase
        end
        // watchdog and prescaler run free
        n.pre = pre_inc[`RRSSE_PRE_W-1:0];
        if (pre_inc[`RRSSE_PRE_W]) begin
            n.watchdog_counter = r.watchdog_counter + 8'h01;
        end
        // bus writes; core registers only while idle
        if (r.dp_wr) begin
            unique case (r.dp_a)
                `RRSSE_A_INSTR: begin
                    if (launch) begin
                        n.op  = hwdata[`RRSSE_OP_MSB:`RRSSE_OP_LSB];
                        n.k   = hwdata[`RRSSE_K_MSB:`RRSSE_K_LSB];
                        n.fa  = hwdata[`RRSSE_F_MSB:`RRSSE_F_LSB];
                        n.d   = hwdata[`RRSSE_D_BIT];
                        n.cyc = 4'h0;
                        n.xs  = rrsse_pkg::xs_run;
                    end
                end
                `RRSSE_A_ACC: begin
                    if (idle) begin
                        n.acc = hwdata[7:0];
                    end
                end
                `RRSSE_A_FLAGS: begin
                    if (idle) begin
                        n.st = hwdata[4:0];
                    end
                end
                `RRSSE_A_PC: begin
                    if (idle) begin
                        n.pc = hwdata[`RRSSE_PC_W-1:0];
                    end
                end
                `RRSSE_A_STACK: begin
                    if (idle) begin
                        n.stk[r.sp] = hwdata[`RRSSE_PC_W-1:0];
                        n.sp        = r.sp + 1'b1;
                    end
                end
                `RRSSE_A_CTRL: begin
                    if (hwdata[0] && (r.xs == rrsse_pkg::xs_sleep)) begin
                        n.xs = rrsse_pkg::xs_idle;
                    end
                end
                `RRSSE_A_FADDR: begin
                    n.faddr = hwdata[`RRSSE_FA_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // execution
        if (running) begin
            n.cyc = r.cyc + 4'h1;
            if (r.cyc == `RRSSE_EXEC_CLK) begin
                unique case (r.op)
                    `RRSSE_OP_RET_LIT: begin
                        n.acc = r.k;
                        n.pc  = stack_head;
                        n.sp  = sp_dec;
                    end
                    `RRSSE_OP_RET: begin
                        n.pc = stack_head;
                        n.sp = sp_dec;
                    end
                    `RRSSE_OP_ROT_R: begin
                        if (!r.d) begin
                            n.acc = rot.res;
                        end
                        n.st.carry = rot.carry;
                    end
                    `RRSSE_OP_SLEEP: begin
                        n.st.power_down_flag = 1'b0;
                        n.st.time_out_flag   = 1'b1;
                        n.watchdog_counter   = `RRSSE_WDOG_CLR;
                        n.pre                = `RRSSE_PRE_CLR;
                    end
                    `RRSSE_OP_LIT_SUB: begin
                        n.acc                 = sub.res;
                        n.st.carry            = sub.carry;
                        n.st.half_borrow_flag = sub.half_borrow_flag;
                        n.st.zero             = sub.zero;
                    end
                    default: begin
                    end
                endcase
            end
            if (r.cyc == last_clk(r.op)) begin
                n.cyc = 4'h0;
                n.xs  = (r.op == `RRSSE_OP_SLEEP) ? rrsse_pkg::xs_sleep
                                                  : rrsse_pkg::xs_idle;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r    <= '0;
            r.st <= `RRSSE_FLAGS_RST;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = (r.rd_wait == 2'h0);
    assign hresp     = 1'b0;
    assign hrdata    = r.rdata;
    assign busy      = !idle;
    assign osc_stop  = (r.xs == rrsse_pkg::xs_sleep);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_two_icyc;
        busy [*8] ##1 !busy;
    endsequence

    sequence s_ret_lit_exec;
        exec_now && (r.op == `RRSSE_OP_RET_LIT);
    endsequence

    sequence s_ret_exec;
        exec_now && (r.op == `RRSSE_OP_RET);
    endsequence

    sequence s_sleep_exec;
        exec_now && (r.op == `RRSSE_OP_SLEEP);
    endsequence

    sequence s_sub_exec;
        exec_now && (r.op == `RRSSE_OP_LIT_SUB);
    endsequence

    sequence s_rot_exec;
        exec_now && (r.op == `RRSSE_OP_ROT_R);
    endsequence

    a_ret_lit_load: assert property (s_ret_lit_exec |=>
        (r.acc == $past(r.k)) && (r.pc == $past(stack_head)))
        else $error("return with literal: accumulator or pc wrong");

    a_ret_lit_len: assert property (
        (launch && (hwdata[`RRSSE_OP_MSB:`RRSSE_OP_LSB] == `RRSSE_OP_RET_LIT))
        |=> s_two_icyc)
        else $error("return with literal not two instruction cycles");

    a_ret_lit_flags: assert property (s_ret_lit_exec |=>
        r.st == $past(r.st))
        else $error("return with literal changed a flag");

    a_rot_carry: assert property (s_rot_exec |=>
        (r.st.carry == $past(mem_rdata[0]))
        && (r.st.zero == $past(r.st.zero))
        && (r.st.half_borrow_flag == $past(r.st.half_borrow_flag)))
        else $error("rotate right carry or other flag wrong");

    a_rot_acc_dest: assert property ((s_rot_exec and !r.d) |=>
        r.acc == {$past(r.st.carry), $past(mem_rdata[7:1])})
        else $error("rotate right to accumulator wrong");

    a_rot_file_dest: assert property (s_rot_exec |->
        (mem_we == r.d) && (!r.d || (mem_wdata == {r.st.carry, mem_rdata[7:1]})))
        else $error("rotate right file write wrong");

    a_ret_pop: assert property (s_ret_exec |=>
        (r.pc == $past(stack_head)) && (r.sp == $past(sp_dec))
        && (r.st == $past(r.st)))
        else $error("return did not pop stack cleanly");

    a_ret_len: assert property (
        (launch && (hwdata[`RRSSE_OP_MSB:`RRSSE_OP_LSB] == `RRSSE_OP_RET))
        |=> s_two_icyc)
        else $error("return not two instruction cycles");

    a_sleep_flags: assert property (s_sleep_exec |=>
        !r.st.power_down_flag && r.st.time_out_flag)
        else $error("power-down flags wrong");

    a_sleep_wdog: assert property (s_sleep_exec |=>
        (r.watchdog_counter == 8'h00) && (r.pre == 3'h0))
        else $error("watchdog not cleared by power-down");

    a_sleep_halt: assert property (s_sleep_exec |-> ##3 osc_stop && busy)
        else $error("core did not halt after power-down");

    a_sub_value: assert property (s_sub_exec |=>
        r.acc == 8'($past(r.k) - $past(r.acc)))
        else $error("literal minus accumulator wrong");

    a_sub_zero: assert property (s_sub_exec |=>
        r.st.zero == (r.acc == 8'h00))
        else $error("zero flag wrong after subtract");

    a_sub_borrow: assert property (s_sub_exec |=>
        (r.st.carry == ($past(r.k) >= $past(r.acc)))
        && (r.st.half_borrow_flag == ($past(r.k[3:0]) >= $past(r.acc[3:0]))))
        else $error("borrow flags wrong after subtract");

endmodule : rrsse_core

/* rrsse_fmem.sv */
/*
 file register memory, a single port: write and registered read share one address.
 assumes a single clock; contents are not reset.
*/
`timescale 1ns/100ps

module rrsse_fmem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input  wire logic          hclk,
    // port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic [DW-1:0]      rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : rrsse_fmem

/* rrsse_params.svh */
/*
 numbered constants of the return/rotate/sleep/subtract execution block:
 register byte offsets, instruction word fields, opcodes, reset values and
 instruction cycle timing. assumes it is included by its bare name.
*/
`ifndef RRSSE_PARAMS_SVH
`define RRSSE_PARAMS_SVH

// register byte offsets (low address byte, upper bits must be zero)
`define RRSSE_A_INSTR      8'h00
`define RRSSE_A_ACC        8'h04
`define RRSSE_A_FLAGS      8'h08
`define RRSSE_A_PC         8'h0c
`define RRSSE_A_STACK      8'h10
`define RRSSE_A_CTRL       8'h14
`define RRSSE_A_FADDR      8'h18
`define RRSSE_A_FDATA      8'h1c
`define RRSSE_A_NONE       8'hff

// instruction word fields
`define RRSSE_OP_MSB       2
`define RRSSE_OP_LSB       0
`define RRSSE_K_MSB        15
`define RRSSE_K_LSB        8
`define RRSSE_F_MSB        22
`define RRSSE_F_LSB        16
`define RRSSE_D_BIT        23

// opcodes
`define RRSSE_OP_NONE      3'h0
`define RRSSE_OP_RET_LIT   3'h1
`define RRSSE_OP_RET       3'h2
`define RRSSE_OP_ROT_R     3'h3
`define RRSSE_OP_SLEEP     3'h4
`define RRSSE_OP_LIT_SUB   3'h5

// widths and reset values
`define RRSSE_FA_W         7
`define RRSSE_PC_W         13
`define RRSSE_PTR_W        3
`define RRSSE_STK_DEPTH    8
`define RRSSE_PRE_W        3
`define RRSSE_FLAGS_RST    5'h18
`define RRSSE_WDOG_CLR     8'h00
`define RRSSE_PRE_CLR      3'h0

// timing: four clocks per instruction cycle
`define RRSSE_EXEC_CLK     4'h1
`define RRSSE_LAST_1ICYC   4'h3
`define RRSSE_LAST_2ICYC   4'h7
`define RRSSE_RD_WAITS     2'h2
`define RRSSE_RD_CAPTURE   2'h1

`endif

/* rrsse_pkg.sv */
/*
 types of the execution block: state codes, flag layout, alu result and the
 whole register state of the core. assumes rrsse_params.svh is reachable.
*/
`include "rrsse_params.svh"

package rrsse_pkg;

    typedef enum logic [1:0] {
        xs_idle,
        xs_run,
        xs_sleep
    } rrsse_xstate_t;

    typedef struct packed {
        logic time_out_flag;
        logic power_down_flag;
        logic zero;
        logic half_borrow_flag;
        logic carry;
    } rrsse_flags_t;

    typedef struct packed {
        logic [7:0] res;
        logic       carry;
        logic       half_borrow_flag;
        logic       zero;
    } rrsse_alu_out_t;

    typedef struct packed {
        logic [7:0]                                        acc;
        rrsse_flags_t                                      st;
        logic [`RRSSE_PC_W-1:0]                            pc;
        logic [`RRSSE_STK_DEPTH-1:0][`RRSSE_PC_W-1:0]      stk;
        logic [`RRSSE_PTR_W-1:0]                           sp;
        rrsse_xstate_t                                     xs;
        logic [2:0]                                        op;
        logic [7:0]                                        k;
        logic [`RRSSE_FA_W-1:0]                            fa;
        logic                                              d;
        logic [3:0]                                        cyc;
        logic [7:0]                                        watchdog_counter;
        logic [`RRSSE_PRE_W-1:0]                           pre;
        logic [`RRSSE_FA_W-1:0]                            faddr;
        logic                                              dp_wr;
        logic [7:0]                                        dp_a;
        logic [1:0]                                        rd_wait;
        logic [31:0]                                       rdata;
    } rrsse_state_t;

endpackage : rrsse_pkg

/* tb_return_rotate_sleep_sub_exec.sv */
/*
 self-checking bench of the execution block, driven over ahb-lite.
 assumes rrsse_params.svh and rrsse_pkg are compiled with the design.
*/
`timescale 1ns/100ps
`include "rrsse_params.svh"

module tb_return_rotate_sleep_sub_exec;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        busy;
    logic        osc_stop;
    int          n_mismatch = 0;
    int          checked    = 0;
    logic [31:0] seed       = 32'h0000001f;
    logic [1:0]  hi         = 2'h3;

    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    rrsse_core u_rrsse_core (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy),
        .osc_stop(osc_stop)
    );

    function automatic logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xrand

    // instruction word: d, file address, literal, opcode
    function automatic logic [31:0] iw(logic [2:0] op, logic [7:0] k, logic [6:0] f, logic d);
        return {8'h0, d, f, k, 5'h0, op};
    endfunction : iw

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wait_ready();
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
    endtask : wait_ready

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_ready();
        htrans <= 2'h0;
        wait_ready();
        d = hrdata;
    endtask : bus_rd

    // issue an instruction, count clocks until idle or halted
    task automatic run_instr(input logic [31:0] w, output int n);
        bus_wr(`RRSSE_A_INSTR, w);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (busy === 1'b1 && osc_stop !== 1'b1);
    endtask : run_instr

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] q;
        logic [15:0] corner [4];
        logic [7:0]  k;
        logic [7:0]  a;
        logic [7:0]  ex;
        logic [12:0] p1;
        logic [12:0] p2;
        int          n;
        corner = '{16'h0000, 16'h0001, 16'h1001, 16'hffff};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus_rd(`RRSSE_A_FLAGS, r);
        check("flags_reset", r, 32'h18);
        bus_rd(`RRSSE_A_NONE, r);
        check("unmapped_read", r, 32'h0);
        check("unmapped_resp", {31'h0, hresp}, 32'h0);
        $display("test reset done");
        // power-down with a running watchdog
        bus_wr(`RRSSE_A_ACC, 32'h3c);
        bus_wr(`RRSSE_A_FLAGS, 32'h1d);
        repeat (100) @(posedge hclk);
        run_instr(iw(`RRSSE_OP_SLEEP, 8'h0, 7'h0, 1'b0), n);
        check("sleep_halt", {30'h0, busy, osc_stop}, 32'h3);
        hi = 2'h2;
        bus_rd(`RRSSE_A_FLAGS, r);
        check("sleep_flags", r, 32'h15);
        bus_rd(`RRSSE_A_CTRL, r);
        check("wdog_clear", {31'h0, r[15:8] <= 8'h02}, 32'h1);
        check("ctrl_asleep", {30'h0, r[1:0]}, 32'h3);
        bus_wr(`RRSSE_A_ACC, 32'h5a);
        bus_wr(`RRSSE_A_CTRL, 32'h1);
        while (busy === 1'b1) begin
            @(posedge hclk);
        end
        bus_rd(`RRSSE_A_ACC, r);
        check("halt_acc_kept", r, 32'h3c);
        $display("test sleep done");
        // literal minus accumulator, corners then random
        for (int i = 0; i < 24; i++) begin
            r = xrand();
            {k, a} = (i < 4) ? corner[i] : r[15:0];
            bus_wr(`RRSSE_A_ACC, {24'h0, a});
            bus_wr(`RRSSE_A_FLAGS, {27'h0, hi, r[18:16]});
            run_instr(iw(`RRSSE_OP_LIT_SUB, k, 7'h0, 1'b0), n);
            ex = k - a;
            bus_rd(`RRSSE_A_ACC, q);
            check("sub_acc", q, {24'h0, ex});
            bus_rd(`RRSSE_A_FLAGS, q);
            check("sub_flags", q, {27'h0, hi, ex == 8'h0, k[3:0] >= a[3:0], k >= a});
        end
        $display("test subtract done");
        // rotate right through carry, both destinations
        for (int i = 0; i < 16; i++) begin
            r = xrand();
            bus_wr(`RRSSE_A_ACC, {24'h0, r[31:24]});
            bus_wr(`RRSSE_A_FLAGS, {27'h0, hi, r[11:10], r[8]});
            bus_wr(`RRSSE_A_FADDR, {25'h0, (i < 2) ? 7'h7f : r[22:16]});
            bus_wr(`RRSSE_A_FDATA, {24'h0, r[7:0]});
            run_instr(iw(`RRSSE_OP_ROT_R, 8'h0, (i < 2) ? 7'h7f : r[22:16], i[0]), n);
            ex = {r[8], r[7:1]};
            bus_rd(`RRSSE_A_ACC, q);
            check("rot_acc", q, {24'h0, i[0] ? r[31:24] : ex});
            bus_rd(`RRSSE_A_FDATA, q);
            check("rot_file", q, {24'h0, i[0] ? ex : r[7:0]});
            bus_rd(`RRSSE_A_FLAGS, q);
            check("rot_flags", q, {27'h0, hi, r[11:10], r[0]});
        end
        $display("test rotate done");
        // return with literal then plain return, back to back
        for (int i = 0; i < 4; i++) begin
            r = xrand();
            p1 = r[12:0];
            p2 = r[28:16];
            k = (i == 0) ? 8'hff : r[31:24];
            bus_wr(`RRSSE_A_STACK, {19'h0, p1});
            bus_wr(`RRSSE_A_STACK, {19'h0, p2});
            bus_wr(`RRSSE_A_FLAGS, {27'h0, hi, r[15:13]});
            run_instr(iw(`RRSSE_OP_RET_LIT, k, 7'h0, 1'b0), n);
            check("retlit_cycles", n, 32'h8);
            bus_rd(`RRSSE_A_ACC, q);
            check("retlit_acc", q, {24'h0, k});
            bus_rd(`RRSSE_A_PC, q);
            check("retlit_pc", q, {19'h0, p2});
            run_instr(iw(`RRSSE_OP_RET, 8'h0, 7'h0, 1'b0), n);
            check("ret_cycles", n, 32'h8);
            bus_rd(`RRSSE_A_PC, q);
            check("ret_pc", q, {19'h0, p1});
            bus_rd(`RRSSE_A_FLAGS, q);
            check("ret_flags", q, {27'h0, hi, r[15:13]});
        end
        $display("test return done");
        // reset in the middle of a two-cycle instruction
        bus_wr(`RRSSE_A_INSTR, iw(`RRSSE_OP_RET_LIT, 8'h5a, 7'h0, 1'b0));
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        check("rst_busy", {30'h0, busy, osc_stop}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        bus_rd(`RRSSE_A_ACC, q);
        check("rst_acc", q, 32'h0);
        bus_rd(`RRSSE_A_FLAGS, q);
        check("rst_flags", q, 32'h18);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : tb_return_rotate_sleep_sub_exec
